// ---- hdl/sfsm_consts.vh ----
// Constants for the serial flash status and map block.
// Assumes a single system clock; included by the core and its bench.
`ifndef SFSM_CONSTS_VH
`define SFSM_CONSTS_VH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define SFSM_CLK_MHZ          50
`define SFSM_NV_WRITE_TIME_US 1000

// ---------------------------------------------------------------
// Status register field positions and reset value
// ---------------------------------------------------------------
`define SFSM_ST_BUSY      0
`define SFSM_ST_LATCH     1
`define SFSM_ST_PROT_LO   2
`define SFSM_ST_PROT_HI   5
`define SFSM_ST_QUAD      6
`define SFSM_ST_LOCK      7
`define SFSM_STATUS_RESET 8'h00

// ---------------------------------------------------------------
// Array map: 4 KB sectors, 32 KB and 64 KB blocks
// ---------------------------------------------------------------
`define SFSM_SECTOR_LSB  12
`define SFSM_BLK32_LSB   15
`define SFSM_BLK64_LSB   16
`define SFSM_ADDR_MSB    20

// ---------------------------------------------------------------
// Instruction codes
// ---------------------------------------------------------------
`define SFSM_OP_WR_ST    8'h01
`define SFSM_OP_PP       8'h02
`define SFSM_OP_WR_DIS   8'h04
`define SFSM_OP_RD_ST    8'h05
`define SFSM_OP_WR_EN    8'h06
`define SFSM_OP_SER_A    8'h20
`define SFSM_OP_SER_B    8'hd7
`define SFSM_OP_PPQ_A    8'h32
`define SFSM_OP_PPQ_B    8'h38
`define SFSM_OP_BE32     8'h52
`define SFSM_OP_BE64     8'hd8
`define SFSM_OP_CE_A     8'hc7
`define SFSM_OP_CE_B     8'h60
`define SFSM_OP_RDFR     8'h48
`define SFSM_OP_RDERP    8'h81
`define SFSM_OP_RSTEN    8'h66
`define SFSM_OP_RST      8'h99
`define SFSM_OP_SUSP     8'h75

// Bit counts of complete instructions
`define SFSM_BITS_OP     6'd8
`define SFSM_BITS_DATA   6'd16
`define SFSM_BITS_ADDR   6'd32

`endif

// ---- hdl/sfsm_core.v ----
// Status register, busy gating and address map of a serial flash.
// Assumes SPI pins arrive asynchronously to clk_sys, which must run
// well above four times the serial clock; array work is done outside.
`include "sfsm_consts.vh"

// Notes on behaviour
// [RULE_01] The array is 4 KB sectors, eight per 32 KB block and sixteen per 64 KB block.
// [RULE_02] A register read keeps repeating the same register until chip select rises.
// [RULE_03] Status bit 0 is a read-only volatile busy flag, 1 while a write cycle runs.
// [RULE_04] Busy stays set for the whole of any program, erase or non-volatile write.
// [RULE_05] While busy only register reads and reset instructions are taken.
// [RULE_06] During a program or erase a suspend instruction is also taken.
// [RULE_07] When an operation ends busy clears and instructions are taken again.
// [RULE_08] Status bit 1 is the volatile write enable latch, set and cleared by its two commands.
// [RULE_09] The write enable latch clears when any write, program or erase completes.
// [RULE_10] Protect bits, quad enable and lock are non-volatile, written by write status, zero at start.
// [RULE_11] Status bits 2 to 5 select which blocks are write protected, zero protects none.
// [RULE_12] Status bit 6 enables the quad input and output function.
// [RULE_13] Status bit 7 write protects the status register; here it only refuses write status while the write protect pin is low.
// [RULE_14] The status register is read whole by its read command, most significant bit first.
// [RULE_15] The busy flag in a repeated status read follows the live internal state.
module sfsm_core #(
    parameter NV_WRITE_CYCLES = `SFSM_NV_WRITE_TIME_US * `SFSM_CLK_MHZ
) (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        spi_sck,
    input  wire        spi_cs_n,
    input  wire        spi_si,
    input  wire        wp_n,
    output wire        spi_so,
    output wire        spi_so_oe,
    output reg         array_op_start,
    output reg  [7:0]  array_op_code,
    output reg  [23:0] array_op_addr,
    input  wire        array_op_done,
    output reg         suspend_req,
    output reg         reset_req,
    output wire [8:0]  sector_index,
    output wire [5:0]  block32_index,
    output wire [4:0]  block64_index,
    output wire        quad_io_enable,
    output wire [7:0]  device_status
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    reg  [2:0]  sck_q;
    reg  [1:0]  cs_q;
    reg         cs_last_q;
    reg  [1:0]  si_q;
    reg  [1:0]  wp_q;

    // Two flops per pin; edge detect looks only at stage two onward
    always @(posedge clk_sys) begin
        if (rst) begin
            sck_q     <= 3'h0;
            cs_q      <= 2'h3;
            cs_last_q <= 1'b1;
            si_q      <= 2'h0;
            wp_q      <= 2'h3;
        end else begin
            sck_q     <= {sck_q[1:0], spi_sck};
            cs_q      <= {cs_q[0], spi_cs_n};
            cs_last_q <= cs_q[1];
            si_q      <= {si_q[0], spi_si};
            wp_q      <= {wp_q[0], wp_n};
        end
    end

    wire sck_rise = sck_q[1] & ~sck_q[2];
    wire sck_fall = ~sck_q[1] & sck_q[2];
    wire cs_low   = ~cs_q[1];
    wire cs_rise  = cs_q[1] & ~cs_last_q;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    reg  [5:0]  cnt_q;
    reg  [31:0] shift_q;
    reg  [7:0]  op_q;
    reg  [7:0]  wrdata_q;
    reg  [23:0] addr_q;
    reg         rd_q;
    reg  [2:0]  rd_idx_q;
    reg         so_q;
    reg         busy_q;
    reg         wen_q;
    reg         nv_wr_q;
    reg  [5:0]  nv_bits_q;
    reg  [5:0]  nv_pend_q;
    reg  [19:0] timer_q;
    wire [7:0]  st_reset = `SFSM_STATUS_RESET;

    // [RULE_03] busy flag bit
    // [RULE_08] latch bit
    assign device_status = {nv_bits_q, wen_q, busy_q};
    // [RULE_12] quad enable bit
    assign quad_io_enable = nv_bits_q[`SFSM_ST_QUAD - 2];

    // [RULE_01] sector and block split
    assign sector_index  = addr_q[`SFSM_ADDR_MSB:`SFSM_SECTOR_LSB];
    assign block32_index = addr_q[`SFSM_ADDR_MSB:`SFSM_BLK32_LSB];
    assign block64_index = addr_q[`SFSM_ADDR_MSB:`SFSM_BLK64_LSB];

    // ---------------------------------------------------------------
    // Protection decode of a 64 KB block
    // ---------------------------------------------------------------
    // [RULE_11] protect level table
    function prot_hit;
        input [3:0] lvl;
        input [4:0] blk;
        begin
            case (lvl)
                4'h0:    prot_hit = 1'b0;
                4'h1:    prot_hit = (blk >= 5'd31);
                4'h2:    prot_hit = (blk >= 5'd30);
                4'h3:    prot_hit = (blk >= 5'd28);
                4'h4:    prot_hit = (blk >= 5'd24);
                4'h5:    prot_hit = (blk >= 5'd16);
                4'ha:    prot_hit = (blk < 5'd16);
                4'hb:    prot_hit = (blk < 5'd8);
                4'hc:    prot_hit = (blk < 5'd4);
                4'hd:    prot_hit = (blk < 5'd2);
                4'he:    prot_hit = (blk == 5'd0);
                4'hf:    prot_hit = 1'b0;
                default: prot_hit = 1'b1;
            endcase
        end
    endfunction

    // ---------------------------------------------------------------
    // Instruction decode at chip select release
    // ---------------------------------------------------------------
    wire [3:0]  prot_lvl  = nv_bits_q[3:0];
    wire [23:0] new_addr  = shift_q[23:0];
    wire        is_pe     = (op_q == `SFSM_OP_PP) || (op_q == `SFSM_OP_PPQ_A) || (op_q == `SFSM_OP_PPQ_B) ||
                            (op_q == `SFSM_OP_SER_A) || (op_q == `SFSM_OP_SER_B) ||
                            (op_q == `SFSM_OP_BE32) || (op_q == `SFSM_OP_BE64);
    wire        is_ce     = (op_q == `SFSM_OP_CE_A) || (op_q == `SFSM_OP_CE_B);
    // [RULE_05] commands allowed while busy
    // [RULE_06] suspend only during array work
    wire        busy_ok   = (op_q == `SFSM_OP_RD_ST) || (op_q == `SFSM_OP_RDFR) || (op_q == `SFSM_OP_RDERP) ||
                            (op_q == `SFSM_OP_RSTEN) || (op_q == `SFSM_OP_RST) ||
                            ((op_q == `SFSM_OP_SUSP) && !nv_wr_q);
    wire        take      = cs_rise && (cnt_q >= `SFSM_BITS_OP) && (!busy_q || busy_ok);
    // [RULE_13] lock with write protect pin low refuses write status
    wire        sr_locked = nv_bits_q[`SFSM_ST_LOCK - 2] && !wp_q[1];
    wire        nv_done   = nv_wr_q && (timer_q == NV_WRITE_CYCLES - 1);
    wire        arr_done  = busy_q && !nv_wr_q && array_op_done;

    // ---------------------------------------------------------------
    // Serial shifter and status read-out
    // ---------------------------------------------------------------
    // Bits shift in on rising edges; status shifts out on falling edges
    always @(posedge clk_sys) begin
        if (rst || !cs_low) begin
            cnt_q    <= 6'h00;
            rd_q     <= 1'b0;
            rd_idx_q <= 3'h0;
            so_q     <= 1'b0;
            if (rst) begin
                shift_q <= 32'h00000000;
                op_q    <= 8'h00;
            end
        end else begin
            if (sck_rise) begin
                shift_q <= {shift_q[30:0], si_q[1]};
                if (cnt_q != 6'h3f) begin
                    cnt_q <= cnt_q + 6'h01;
                end
                if (cnt_q == `SFSM_BITS_OP - 6'h01) begin
                    op_q <= {shift_q[6:0], si_q[1]};
                    // [RULE_14] read status command opens read-out
                    rd_q <= ({shift_q[6:0], si_q[1]} == `SFSM_OP_RD_ST);
                end
            end
            if (sck_fall && rd_q) begin
                // [RULE_15] live busy sampled at every bit
                // [RULE_14] most significant bit first
                so_q     <= device_status[3'h7 - rd_idx_q];
                // [RULE_02] index wraps to repeat the byte
                rd_idx_q <= rd_idx_q + 3'h1;
            end
        end
    end

    assign spi_so    = so_q;
    assign spi_so_oe = rd_q & cs_low;

    // Capture data byte and address as they complete
    always @(posedge clk_sys) begin
        if (rst) begin
            wrdata_q <= 8'h00;
            addr_q   <= 24'h000000;
        end else if (cs_low && sck_rise) begin
            if (cnt_q == `SFSM_BITS_DATA - 6'h01) begin
                wrdata_q <= {shift_q[6:0], si_q[1]};
            end
            if (cnt_q == `SFSM_BITS_ADDR - 6'h01) begin
                addr_q <= {new_addr[22:0], si_q[1]};
            end
        end
    end

    // ---------------------------------------------------------------
    // Status bits, busy and array requests
    // ---------------------------------------------------------------
    // Completion is checked before new work, so a start in the same cycle wins
    always @(posedge clk_sys) begin
        if (rst) begin
            busy_q         <= 1'b0;
            wen_q          <= 1'b0;
            nv_wr_q        <= 1'b0;
            // [RULE_10] factory value zero
            nv_bits_q      <= st_reset[7:2];
            nv_pend_q      <= 6'h00;
            timer_q        <= 20'h00000;
            array_op_start <= 1'b0;
            array_op_code  <= 8'h00;
            array_op_addr  <= 24'h000000;
            suspend_req    <= 1'b0;
            reset_req      <= 1'b0;
        end else begin
            array_op_start <= 1'b0;
            suspend_req    <= 1'b0;
            reset_req      <= 1'b0;
            if (nv_wr_q) begin
                timer_q <= timer_q + 20'h00001;
            end
            // [RULE_07] busy ends on completion, success or not
            // [RULE_09] latch drops with it
            if (nv_done || arr_done) begin
                busy_q  <= 1'b0;
                wen_q   <= 1'b0;
                nv_wr_q <= 1'b0;
                if (nv_done) begin
                    // [RULE_10] new cells land at the end of the write
                    nv_bits_q <= nv_pend_q;
                end
            end
            if (take) begin
                case (op_q)
                    // [RULE_08] only these two commands move the latch; completion also clears it
                    `SFSM_OP_WR_EN:  if (cnt_q == `SFSM_BITS_OP) wen_q <= 1'b1;
                    `SFSM_OP_WR_DIS: if (cnt_q == `SFSM_BITS_OP) wen_q <= 1'b0;
                    `SFSM_OP_WR_ST: begin
                        // [RULE_04] busy through the non-volatile write
                        if (cnt_q >= `SFSM_BITS_DATA && wen_q && !sr_locked) begin
                            nv_pend_q <= wrdata_q[7:2];
                            nv_wr_q   <= 1'b1;
                            busy_q    <= 1'b1;
                            timer_q   <= 20'h00000;
                        end
                    end
                    `SFSM_OP_SUSP:  suspend_req <= busy_q;
                    `SFSM_OP_RST:   reset_req   <= 1'b1;
                    default: begin
                        // [RULE_04] busy through program or erase
                        if (wen_q && ((is_pe && cnt_q >= `SFSM_BITS_ADDR &&
                                       !prot_hit(prot_lvl, addr_q[`SFSM_ADDR_MSB:`SFSM_BLK64_LSB])) ||
                                      (is_ce && cnt_q == `SFSM_BITS_OP && prot_lvl == 4'h0))) begin
                            busy_q         <= 1'b1;
                            array_op_start <= 1'b1;
                            array_op_code  <= op_q;
                            array_op_addr  <= addr_q;
                        end
                    end
                endcase
            end
        end
    end

endmodule // sfsm_core

// ---- test/sfsm_core_asserts.sv ----
// Checker for the flash status block, bound to its top ports.
// Assumes one clock clk_sys and synchronous active-high rst.
module sfsm_core_asserts (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       spi_cs_n,
    input wire logic       spi_so_oe,
    input wire logic       array_op_start,
    input wire logic       array_op_done,
    input wire logic       quad_io_enable,
    input wire logic [7:0] device_status
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Properties on the status byte and the output enable
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_oe_off_idle: assert property (spi_cs_n [*5] |-> !spi_so_oe)
        else $error("output enable left on while deselected");
    a_start_sets_busy: assert property (array_op_start |-> ##[0:1] device_status[0])
        else $error("busy not set by array start");
    a_start_when_idle: assert property (array_op_start |-> !$past(device_status[0]))
        else $error("array start while busy");
    a_done_clears_busy: assert property (device_status[0] && array_op_done |=> !device_status[0])
        else $error("busy not cleared by done");
    a_wel_rise_frame: assert property ($rose(device_status[1]) |-> spi_cs_n)
        else $error("write latch rose inside a frame");
    a_busy_end_wel: assert property ($fell(device_status[0]) |-> !device_status[1])
        else $error("write latch kept after completion");
    a_start_needs_wel: assert property (array_op_start |-> $past(device_status[1]))
        else $error("array start without write latch");
    a_nv_bits_busy: assert property ($changed(device_status[7:2]) |-> $past(device_status[0]))
        else $error("stored bits changed outside a write");
    a_quad_mirror: assert property (quad_io_enable == device_status[6])
        else $error("quad enable differs from status bit");
endmodule // sfsm_core_asserts

// ---- test/sfsm_host.sv ----
// Host model that drives the serial pins of the flash block.
// Assumes mode 0; one sck half period is five system clocks.
module sfsm_host (
    input  wire logic clk_sys,
    input  wire logic so_line,
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_si
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rd_q = 16'h0000;
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end
    // Half period; slow sck keeps the pin synchronisers honest
    task automatic half(input logic lvl);
        repeat (5) @(posedge clk_sys);
        spi_sck <= lvl;
    endtask
    task automatic xfer(input logic [31:0] d, input int nb, input int nr);
        int i;
        @(posedge clk_sys);
        spi_cs_n <= 1'b0;
        for (i = 0; i < nb + nr; i++) begin
            spi_si <= (i < nb) ? d[31 - i] : ~spi_si; // Toggles once unused
            half(1'b1);
            if (i >= nb) rd_q <= {rd_q[14:0], so_line};
            half(1'b0);
        end
        repeat (5) @(posedge clk_sys);
        spi_cs_n <= 1'b1;
        spi_si <= ~spi_si;
        repeat (8) @(posedge clk_sys); // Gap well over four clocks
    endtask
endmodule // sfsm_host

// ---- test/sfsm_core_tb.sv ----
// Self-checking bench for the flash status block.
// Assumes the host model and checker are compiled first.
`include "sfsm_consts.vh"
module sfsm_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst = 1'b1, wp_n = 1'b1, array_op_done = 1'b0;
    logic susp_seen = 1'b0, rst_seen = 1'b0;
    wire spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, array_op_start, suspend_req, reset_req, quad_io_enable;
    wire [7:0] array_op_code, device_status;
    wire [23:0] array_op_addr;
    wire [8:0] sector_index;
    wire [5:0] block32_index;
    wire [4:0] block64_index;
    wire so_line = spi_so_oe ? spi_so : 1'b1; // Pulled up when released
    int miscompares = 0, compares = 0;
    always #10 clk_sys = ~clk_sys;
    sfsm_host h (.clk_sys(clk_sys), .so_line(so_line), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si));
    sfsm_core #(.NV_WRITE_CYCLES(400)) dut (.clk_sys(clk_sys), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_si(spi_si), .wp_n(wp_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .array_op_start(array_op_start),
        .array_op_code(array_op_code), .array_op_addr(array_op_addr), .array_op_done(array_op_done),
        .suspend_req(suspend_req), .reset_req(reset_req), .sector_index(sector_index),
        .block32_index(block32_index), .block64_index(block64_index), .quad_io_enable(quad_io_enable),
        .device_status(device_status));
    // Pulses are short, so remember them
    always @(posedge clk_sys) begin
        if (suspend_req) susp_seen <= 1'b1;
        if (reset_req) rst_seen <= 1'b1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Bounded wait for the busy flag to drop
    task automatic wait_idle;
        int n;
        for (n = 0; n < 2000 && device_status[0] !== 1'b0; n++) @(posedge clk_sys);
        if (n >= 2000) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic op8(input logic [7:0] op);
        h.xfer({op, 24'h0}, 8, 0);
    endtask
    initial begin
        #1000000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(device_status, `SFSM_STATUS_RESET);
        h.xfer({`SFSM_OP_WR_ST, 8'hfc, 16'h0}, 16, 0);
        chk(device_status, 8'h00);
        op8(`SFSM_OP_WR_EN);
        h.xfer({`SFSM_OP_RD_ST, 24'h0}, 8, 16);
        chk(h.rd_q, 16'h0202);
        op8(`SFSM_OP_WR_DIS);
        chk(device_status, 8'h00);
        // Stored write holds busy, ignores other commands
        op8(`SFSM_OP_WR_EN);
        h.xfer({`SFSM_OP_WR_ST, 8'hff, 16'h0}, 16, 0);
        chk(device_status[0], 1'b1);
        op8(`SFSM_OP_WR_DIS);
        chk(device_status[1], 1'b1);
        wait_idle();
        chk(device_status, 8'hfc);
        chk(quad_io_enable, 1'b1);
        // Protect top block, then refused program and erase
        op8(`SFSM_OP_WR_EN);
        h.xfer({`SFSM_OP_WR_ST, 8'h84, 16'h0}, 16, 0);
        wait_idle();
        chk(device_status, 8'h84);
        op8(`SFSM_OP_WR_EN);
        h.xfer({`SFSM_OP_PP, 24'h1f0000}, 32, 0);
        op8(`SFSM_OP_CE_A);
        chk(device_status, 8'h86);
        // Lock with pin low refuses writes
        wp_n <= 1'b0;
        h.xfer({`SFSM_OP_WR_ST, 8'h00, 16'h0}, 16, 0);
        chk(device_status, 8'h86);
        wp_n <= 1'b1;
        // Program an open block, map its address
        h.xfer({`SFSM_OP_PP, 24'h0e3456}, 32, 0);
        chk(device_status[0], 1'b1);
        chk({array_op_code, array_op_addr}, {8'h02, 24'h0e3456});
        chk({sector_index, block32_index, block64_index}, {9'h0e3, 6'h1c, 5'h0e});
        // Suspend and reset taken while busy
        op8(`SFSM_OP_SUSP);
        op8(`SFSM_OP_RST);
        chk({susp_seen, rst_seen}, 2'b11);
        // Busy falls inside one long status read
        fork
            h.xfer({`SFSM_OP_RD_ST, 24'h0}, 8, 16);
            begin
                repeat (190) @(posedge clk_sys);
                array_op_done <= 1'b1;
                @(posedge clk_sys);
                array_op_done <= 1'b0;
            end
        join
        chk({h.rd_q[8], h.rd_q[0]}, 2'b10);
        chk({h.rd_q[15:10], h.rd_q[7:2]}, {6'h21, 6'h21});
        chk(device_status, 8'h84);
        op8(`SFSM_OP_WR_EN);
        chk(device_status, 8'h86);
        summarize();
    end
endmodule // sfsm_core_tb
bind sfsm_core sfsm_core_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe),
    .array_op_start(array_op_start), .array_op_done(array_op_done), .quad_io_enable(quad_io_enable),
    .device_status(device_status));
